//--- design/eeprom_write_path.sv
// Write path: takes item streams from the interpreter and commits bytes to storage
// Summary of operation
// - Address 0-2047, or 0-255 on smallest.
// - Values are bytes, or 16-bit with word flag.
// - Word: low byte at address, high next.
// - Multi-item request writes consecutive addresses.
// - Writes go into the selected slot.
// - Every address writable, no protection.
// - Committed data retained in nonvolatile array.
// - Slot defaults to running slot on start.
// - Slot range 0-7 or 0-15 per variant, slot 0 only on smallest and one-slot.
module eeprom_write_path (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [1:0] VARIANT_I,
  input wire logic [nvwr_pkg::SLOT_W-1:0] RUN_SLOT_I,
  input wire logic RUN_START_I,
  input wire logic SEL_VALID_I,
  input wire logic [nvwr_pkg::SLOT_W-1:0] SEL_SLOT_I,
  input wire logic START_VALID_I,
  input wire logic [nvwr_pkg::ADDR_W-1:0] START_ADDR_I,
  output logic START_READY_O,
  input wire logic ITEM_VALID_I,
  input wire nvwr_pkg::item_s ITEM_I,
  output logic ITEM_READY_O,
  output logic DONE_O,
  output logic [nvwr_pkg::SLOT_W-1:0] WR_SLOT_O,
  input wire logic [nvwr_pkg::MEM_AW-1:0] RD_ADDR_I,
  output logic [7:0] RD_DATA_O
);
  import nvwr_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ITEM = 2'b01,
    ST_HIGH = 2'b10
  } state_e;

  state_e state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [SLOT_W-1:0] slot_q;
  logic [7:0] high_q;
  logic last_q;
  logic done_q;
  byte_wr_s wr_d;
  logic wr_en_d;

  function automatic logic [ADDR_W-1:0] addr_limit(input logic [1:0] v);
    addr_limit = (v == VARIANT_SMALL) ? ADDR_MAX_SMALL : ADDR_MAX_LARGE;
  endfunction

  function automatic logic [SLOT_W-1:0] slot_limit(input logic [1:0] v);
    case (v)
      VARIANT_8_SLOT: slot_limit = SLOT_MAX_8;
      VARIANT_16_SLOT: slot_limit = SLOT_MAX_16;
      default: slot_limit = SLOT_RST;
    endcase
  endfunction

  // Address wraps within the variant's space, so a run past the top address continues at address 0
  function automatic logic [ADDR_W-1:0] wrap(input logic [ADDR_W-1:0] a, input logic [1:0] v);
    wrap = a & addr_limit(v);
  endfunction

  function automatic logic [MEM_AW-1:0] phys(input logic [SLOT_W-1:0] s, input logic [ADDR_W-1:0] a);
    phys = {s, a};
  endfunction

  assign START_READY_O = (state_q == ST_IDLE);
  assign ITEM_READY_O = (state_q == ST_ITEM);
  assign DONE_O = done_q;
  assign WR_SLOT_O = slot_q;

  // Write slot: run start overrides a same-cycle select, since the new program owns the bank
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      slot_q <= SLOT_RST;
    end else if (RUN_START_I) begin
      slot_q <= RUN_SLOT_I & slot_limit(VARIANT_I);
    end else if (SEL_VALID_I) begin
      slot_q <= SEL_SLOT_I & slot_limit(VARIANT_I);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (START_VALID_I) begin
            state_q <= ST_ITEM;
          end
        end
        ST_ITEM: begin
          if (ITEM_VALID_I && ITEM_I.is_word) begin
            state_q <= ST_HIGH;
          end else if (ITEM_VALID_I && ITEM_I.last) begin
            state_q <= ST_IDLE;
          end
        end
        ST_HIGH: begin
          state_q <= last_q ? ST_IDLE : ST_ITEM;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // One byte per cycle, so a word item advances the address by two over two cycles
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      addr_q <= '0;
    end else if (state_q == ST_IDLE && START_VALID_I) begin
      addr_q <= wrap(START_ADDR_I, VARIANT_I);
    end else if ((state_q == ST_ITEM && ITEM_VALID_I) || state_q == ST_HIGH) begin
      addr_q <= wrap(addr_q + STEP_BYTE, VARIANT_I);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      high_q <= '0;
      last_q <= 1'b0;
    end else if (state_q == ST_ITEM && ITEM_VALID_I) begin
      high_q <= ITEM_I.value[15:8];
      last_q <= ITEM_I.last;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_ITEM && ITEM_VALID_I && ITEM_I.last && !ITEM_I.is_word)
                || (state_q == ST_HIGH && last_q);
    end
  end

  // No address is guarded: program code bytes are as writable as data
  always_comb begin
    wr_en_d = 1'b0;
    wr_d = '0;
    if (state_q == ST_ITEM && ITEM_VALID_I) begin
      wr_en_d = 1'b1;
      wr_d.addr = phys(slot_q, addr_q);
      wr_d.data = ITEM_I.value[7:0];
    end else if (state_q == ST_HIGH) begin
      wr_en_d = 1'b1;
      wr_d.addr = phys(slot_q, addr_q);
      wr_d.data = high_q;
    end
  end

  nv_store u_store (
    .CLOCK_I(CLOCK_I),
    .wr_i(wr_d),
    .wr_en_i(wr_en_d),
    .rd_addr_i(RD_ADDR_I),
    .rd_data_o(RD_DATA_O)
  );
endmodule

//--- design/nv_store.sv
// Nonvolatile byte store: array with a single byte write port and read port
module nv_store (
  input wire logic CLOCK_I,
  input wire nvwr_pkg::byte_wr_s wr_i,
  input wire logic wr_en_i,
  input wire logic [nvwr_pkg::MEM_AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  import nvwr_pkg::*;
  // No reset on purpose: contents must survive reset like the real cells
  logic [7:0] mem_q [0:MEM_BYTES-1];

  always_ff @(posedge CLOCK_I) begin
    if (wr_en_i) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

//--- design/nvwr_pkg.sv
// Shared constants and carrier types for the nonvolatile write path
package nvwr_pkg;
  localparam int ADDR_W = 11;
  localparam int SLOT_W = 4;
  localparam int BANK_BYTES = 2048;
  localparam int MEM_BYTES = 16 * BANK_BYTES;
  localparam int MEM_AW = ADDR_W + SLOT_W;
  localparam logic [ADDR_W-1:0] ADDR_MAX_LARGE = 11'h7FF;
  localparam logic [ADDR_W-1:0] ADDR_MAX_SMALL = 11'h0FF;
  localparam logic [SLOT_W-1:0] SLOT_MAX_8 = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_MAX_16 = 4'hF;
  localparam logic [SLOT_W-1:0] SLOT_RST = 4'h0;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 11'h001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 11'h002;
  localparam logic [1:0] VARIANT_SMALL = 2'h0;
  localparam logic [1:0] VARIANT_ONE_SLOT = 2'h1;
  localparam logic [1:0] VARIANT_8_SLOT = 2'h2;
  localparam logic [1:0] VARIANT_16_SLOT = 2'h3;
  // One value of a write request
  typedef struct packed {
    logic is_word;
    logic [15:0] value;
    logic last;
  } item_s;
  // Byte write into the storage array
  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [7:0] data;
  } byte_wr_s;
endpackage

//--- dv/eeprom_write_path_monitor.sv
// Handshake and completion checker for the write path
module eeprom_write_path_monitor (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic START_VALID_I,
  input wire logic START_READY_O,
  input wire logic ITEM_VALID_I,
  input wire nvwr_pkg::item_s ITEM_I,
  input wire logic ITEM_READY_O,
  input wire logic DONE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  import nvwr_pkg::*;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  wire tk = ITEM_VALID_I && ITEM_READY_O;
  wire tkb = tk && !ITEM_I.is_word;
  wire tkw = tk && ITEM_I.is_word;
  a_start_busy: assert property (START_VALID_I && START_READY_O |=> !START_READY_O && ITEM_READY_O)
    else $error("start not taken");
  a_idle_items: assert property (START_READY_O |-> !ITEM_READY_O)
    else $error("item ready in idle");
  a_word_gap: assert property (tkw |=> !ITEM_READY_O && !DONE_O)
    else $error("no high byte cycle");
  a_word_done: assert property (tkw && ITEM_I.last |=> ##1 DONE_O)
    else $error("word done late");
  a_byte_done: assert property (tkb && ITEM_I.last |=> DONE_O)
    else $error("byte done late");
  a_byte_next: assert property (tkb && !ITEM_I.last |=> ITEM_READY_O && !DONE_O)
    else $error("stall after byte");
  a_done_pulse: assert property (DONE_O |-> START_READY_O ##1 !DONE_O)
    else $error("done not a pulse");
  a_done_cause: assert property (DONE_O |-> $past(tkb && ITEM_I.last) || $past(tkw && ITEM_I.last, 2))
    else $error("done without last");
  c_word_last: cover property (tkw && ITEM_I.last);
  c_byte_last: cover property (tkb && ITEM_I.last);
  c_word_mid: cover property (tkw && !ITEM_I.last);
endmodule

//--- dv/eeprom_write_path_test.sv
// Self-checking bench for the write path
module eeprom_write_path_test;
  timeunit 1ns;
  timeprecision 100ps;
  import nvwr_pkg::*;
  logic clk = 0, rst_n = 0, run = 0, sel = 0, rv = 0, rv_q = 0, sv, srdy, iv, irdy, done, stuck;
  logic [SLOT_W-1:0] rslot = '0, sslot = '0, slot;
  logic [MEM_AW-1:0] ra = '0, wa_q[$];
  logic [7:0] rd, exp_q[$], wd_q[$];
  logic [ADDR_W-1:0] sa;
  item_s it;
  logic [1:0] variant = VARIANT_16_SLOT;
  int mismatches = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  eeprom_write_path i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .VARIANT_I(variant), .RUN_SLOT_I(rslot),
    .RUN_START_I(run), .SEL_VALID_I(sel), .SEL_SLOT_I(sslot), .START_VALID_I(sv), .START_ADDR_I(sa),
    .START_READY_O(srdy), .ITEM_VALID_I(iv), .ITEM_I(it), .ITEM_READY_O(irdy), .DONE_O(done),
    .WR_SLOT_O(slot), .RD_ADDR_I(ra), .RD_DATA_O(rd));
  req_source i_src (.clk_i(clk), .srdy_i(srdy), .irdy_i(irdy), .sv_o(sv), .sa_o(sa), .iv_o(iv), .it_o(it),
    .stuck_o(stuck));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (e !== g) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic request(input logic [ADDR_W-1:0] a, input int p);
    item_s x;
    int n = 0;
    i_src.start(a);
    for (int k = 0; k < 3; k++) begin
      x.is_word = 1'((k + p) % 2);
      x.value = x.is_word ? 16'($urandom) : 16'($urandom % 256);
      x.last = k == 2;
      for (int b = 0; b <= int'(x.is_word); b++) begin
        wa_q.push_back({4'(p + 5), a});
        wd_q.push_back(x.value[8*b +: 8]);
        a++;
      end
      i_src.item(x);
    end
    i_src.idle();
    while (done !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (stuck || n == 8) mismatches++;
    if (stuck || n == 8) report_and_stop();
  endtask
  always @(posedge clk) begin
    if (rv_q) chk("read data", exp_q.pop_front(), rd);
    rv_q <= rv;
  end
  initial begin
    void'($urandom(12));
    repeat (20) @(negedge clk);
    rst_n = 1;
    chk("slot", 8'(SLOT_RST), 8'(slot));
    for (int p = 0; p < 2; p++) begin
      sel = 1;
      sslot = 4'(p + 5);
      @(negedge clk);
      sel = 0;
      chk("slot", 8'(p + 5), 8'(slot));
      request(p ? 11'h07FF : 11'($urandom), p);
    end
    rslot = 4'($urandom);
    sslot = ~rslot;
    {run, sel} = 2'b11;
    @(negedge clk);
    {run, sel} = 2'b00;
    chk("slot", 8'(rslot), 8'(slot));
    // Eight-slot variant keeps only slots 0 to 7 of the selector
    variant = VARIANT_8_SLOT;
    sslot = 4'hD;
    sel = 1;
    @(negedge clk);
    sel = 0;
    chk("slot", 8'h05, 8'(slot));
    variant = VARIANT_16_SLOT;
    while (wa_q.size() > 0) begin
      ra = wa_q.pop_front();
      exp_q.push_back(wd_q.pop_front());
      rv = 1;
      @(negedge clk);
    end
    rv = 0;
    repeat (3) @(negedge clk);
    report_and_stop();
  end
endmodule
bind eeprom_write_path eeprom_write_path_monitor i_mon (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
  .START_VALID_I(START_VALID_I), .START_READY_O(START_READY_O), .ITEM_VALID_I(ITEM_VALID_I), .ITEM_I(ITEM_I),
  .ITEM_READY_O(ITEM_READY_O), .DONE_O(DONE_O));

//--- dv/req_source.sv
// Interpreter model: issues start and item requests, holding each until taken
module req_source (
  input wire logic clk_i,
  input wire logic srdy_i,
  input wire logic irdy_i,
  output logic sv_o = 0,
  output logic [nvwr_pkg::ADDR_W-1:0] sa_o = '0,
  output logic iv_o = 0,
  output nvwr_pkg::item_s it_o = '0,
  output logic stuck_o = 0
);
  timeunit 1ns;
  timeprecision 100ps;
  // Ready is combinational, so it is read before the edge, not after it moves
  task automatic hold(input logic w);
    logic r;
    int n = 0;
    do begin
      #1 r = w ? irdy_i : srdy_i;
      @(posedge clk_i);
      n++;
    end while (!r && n < 64);
    stuck_o |= !r;
  endtask
  task automatic start(input logic [nvwr_pkg::ADDR_W-1:0] a);
    @(negedge clk_i);
    sv_o = 1;
    sa_o = a;
    hold(0);
  endtask
  task automatic item(input nvwr_pkg::item_s x);
    @(negedge clk_i);
    sv_o = 0;
    iv_o = 1;
    it_o = x;
    hold(1);
  endtask
  // Released lines flip so a stale value never passes for a fresh one
  task automatic idle();
    @(negedge clk_i);
    iv_o = 0;
    it_o = ~it_o;
    sa_o = ~sa_o;
  endtask
endmodule
